// ==== sim/fcr_flash_model.sv ====
// fcr_flash_model: behavioural byte-wide flash with a command register
// assumes host drives ce_n/we_n/oe_n; dq_bus is the resolved data wire
`timescale 1ns/100ps
module fcr_flash_model #(
  parameter logic [7:0] MAKER_ID = 8'h3c, // arbitrary
  parameter logic [7:0] PART_ID = 8'hc5 // arbitrary
)(
  input wire ce_n,
  input wire oe_n,
  input wire we_n,
  input wire [15:0] addr,
  input wire [7:0] dq_bus,
  input wire vpp,
  output logic [7:0] dq_out,
  output int viol,
  output int ff_writes,
  output logic [2:0] mode
);
  logic [7:0] mem [256];
  logic [7:0] pd, rd, last;
  logic [15:0] pa;
  realtime t_vpp, t_stop;
  initial begin
    foreach (mem[i]) mem[i] = 8'(i) ^ 8'h5a;
    mode = 3'h0;
    viol = 0;
    ff_writes = 0;
    t_vpp = 0;
    t_stop = -1.0e9;
    last = 8'h00;
  end
  always @(posedge vpp) t_vpp = $realtime;
  // host timing faults are counted, the bench judges them
  // ce_n falls in the same step as oe_n, so only oe_n is keyed on
  always @(negedge oe_n) if ($realtime - t_stop < 6000.0) viol++;
  always @(posedge we_n) if (!ce_n) begin
    if (vpp && $realtime - t_vpp < 100.0) viol++;
    if (dq_bus == 8'hff) ff_writes++;
    case (mode)
      3'h2: begin
        pa = addr;
        pd = dq_bus;
        mode = 3'h3;
      end
      3'h3: if (dq_bus == 8'hc0) begin
        if (vpp) mem[pa[7:0]] = mem[pa[7:0]] & pd;
        t_stop = $realtime;
        mode = 3'h4;
      end else if (dq_bus == 8'hff) mode = 3'h0;
      3'h5: mode = (dq_bus == 8'h20 && vpp) ? 3'h6 : 3'h0;
      3'h6: if (dq_bus == 8'ha0) begin
        // erase lands whole at verify; runs until then or until an ffh write returns to read
        foreach (mem[i]) mem[i] = 8'hff;
        pa = addr;
        t_stop = $realtime;
        mode = 3'h4;
      end else if (dq_bus == 8'hff) mode = 3'h0;
      default: case (dq_bus)
        8'h00, 8'hff: mode = 3'h0;
        8'h80, 8'h90: mode = 3'h1;
        8'h40: mode = vpp ? 3'h2 : 3'h0;
        8'h20: mode = vpp ? 3'h5 : 3'h0;
        8'ha0: begin
          pa = addr;
          t_stop = $realtime;
          mode = 3'h4;
        end
        default: mode = mode;
      endcase
    endcase
  end
  always_comb begin
    if (mode == 3'h1) rd = (addr == 16'h0000) ? MAKER_ID : (addr == 16'h0001) ? PART_ID : 8'h00;
    else if (mode == 3'h4) rd = mem[pa[7:0]];
    else rd = mem[addr[7:0]];
  end
  always @(posedge oe_n) last = rd;
  // released bus shows a changed value, not a stale one
  assign dq_out = (!ce_n && !oe_n) ? rd : ~last;
endmodule

// ==== sim/tb.sv ====
// tb: scenarios for the flash host controller against the flash model
// assumes the model starts with byte i holding i xor 5ah
`timescale 1ns/100ps
module tb;
  import fcr_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic cmd_valid = 1'b0;
  logic [2:0] cmd_op = 3'h0;
  logic [15:0] cmd_addr = 16'h0000;
  logic [7:0] cmd_data = 8'h00;
  logic abort_req = 1'b0;
  logic cmd_ready, rsp_valid, rsp_fail, vpp_en, fl_dq_oe, fl_ce_n, fl_oe_n, fl_we_n, fail;
  logic [7:0] rsp_data, fl_dq_o, dev_dq, dq_bus, got;
  logic [15:0] fl_addr;
  logic [2:0] mode;
  int viol, ff_writes, num_errors = 0, check_count = 0;
  assign dq_bus = fl_dq_oe ? fl_dq_o : dev_dq;
  fcr_host #(.ERASE_CYC(200)) dut (.clock(clock), .rst(rst), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .abort_req(abort_req),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_fail(rsp_fail),
    .vpp_en(vpp_en), .fl_addr(fl_addr), .fl_dq_o(fl_dq_o), .fl_dq_oe(fl_dq_oe),
    .fl_dq_i(dq_bus), .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n));
  fcr_flash_model flash (.ce_n(fl_ce_n), .oe_n(fl_oe_n), .we_n(fl_we_n), .addr(fl_addr),
    .dq_bus(dq_bus), .vpp(vpp_en), .dq_out(dev_dq), .viol(viol), .ff_writes(ff_writes),
    .mode(mode));
  task automatic complete_run();
    $display("mismatches %0d comparisons %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] seen);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  // abort_at counts cycles after acceptance; 0 means never
  task automatic run_op(input fcr_op_t op, input logic [15:0] a, input logic [7:0] d,
      input int abort_at);
    int n;
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_addr <= a;
    cmd_data <= d;
    n = 0;
    do begin @(posedge clock); n++; end while (cmd_ready !== 1'b1 && n < 100);
    cmd_valid <= 1'b0;
    if (cmd_ready !== 1'b1) begin
      num_errors++;
      $display("unexpected ready wait: expected 1 seen 0");
      complete_run();
    end
    n = 0;
    do begin
      @(posedge clock);
      n++;
      if (n == abort_at) abort_req <= 1'b1;
    end while (rsp_valid !== 1'b1 && n < 10000);
    abort_req <= 1'b0;
    got = rsp_data;
    fail = rsp_fail;
    if (rsp_valid !== 1'b1) begin
      num_errors++;
      $display("unexpected response wait: expected 1 seen 0");
      complete_run();
    end
  endtask
  task automatic t_reset();
    check8("ready after reset", 8'h01, {7'h00, cmd_ready});
    check8("strobes after reset", 8'h07, {5'h00, fl_ce_n, fl_oe_n, fl_we_n});
    check8("drive and vpp after reset", 8'h00, {6'h00, fl_dq_oe, vpp_en});
    check8("mode at power-up", 8'h00, {5'h00, mode});
  endtask
  task automatic t_read_prog();
    run_op(FCR_OP_READ, 16'h0003, 8'h00, 0);
    check8("array read", 8'h59, got);
    run_op(FCR_OP_PROGRAM, 16'h0003, 8'h0f, 0);
    check8("program verify data", 8'h09, got);
    check8("program fail", 8'h00, {7'h00, fail});
    check8("vpp after program", 8'h00, {7'h00, vpp_en});
    run_op(FCR_OP_READ, 16'h0003, 8'h00, 0);
    check8("read after program", 8'h09, got);
    run_op(FCR_OP_PROGRAM, 16'h0004, 8'h00, 400);
    check8("aborted program fail", 8'h01, {7'h00, fail});
    check8("pulse left open", 8'h00, {7'h00, mode == 3'h3});
  endtask
  task automatic t_ident_reset();
    int f;
    run_op(FCR_OP_IDENT, 16'h0000, 8'h00, 0);
    check8("maker code", 8'h3c, got);
    run_op(FCR_OP_IDENT, 16'h0001, 8'h00, 0);
    check8("part code", 8'hc5, got);
    check8("ident held", 8'h01, {5'h00, mode});
    f = ff_writes;
    run_op(FCR_OP_RESET, 16'h0000, 8'h00, 0);
    check8("mode after reset", 8'h00, {5'h00, mode});
    check8("reset writes", 8'h02, 8'(ff_writes - f));
    run_op(FCR_OP_READ, 16'h0003, 8'h00, 0);
    check8("read after reset", 8'h09, got);
    run_op(FCR_OP_IDENT, 16'h0000, 8'h00, 0);
    run_op(FCR_OP_DESELECT, 16'h0000, 8'h00, 0);
    check8("mode after deselect", 8'h00, {5'h00, mode});
  endtask
  task automatic t_erase();
    run_op(FCR_OP_ERASE, 16'h0003, 8'h00, 0);
    check8("erase verify data", 8'hff, got);
    check8("erase fail", 8'h00, {7'h00, fail});
    check8("erase left running", 8'h00, {7'h00, mode == 3'h6});
    run_op(FCR_OP_ERASE_VERIFY, 16'h0007, 8'h00, 0);
    check8("erase verify op", 8'hff, got);
    run_op(FCR_OP_ERASE, 16'h0003, 8'h00, 100);
    check8("aborted erase fail", 8'h01, {7'h00, fail});
    check8("aborted erase running", 8'h00, {7'h00, mode == 3'h6});
    run_op(FCR_OP_READ, 16'h0003, 8'h00, 0);
    check8("read after erase", 8'hff, got);
  endtask
  initial forever #4 clock = ~clock;
  initial begin
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    t_reset();
    t_read_prog();
    t_ident_reset();
    t_erase();
    check8("host timing faults", 8'h00, 8'(viol));
    complete_run();
  end
endmodule

// ==== verilog/fcr_bus_if.sv ====
// fcr_bus_if: single bus cycle request between sequencer and cycle engine
// assumes both ends on the same clock
`timescale 1ns/100ps
interface fcr_bus_if;
  logic req;
  logic wr;
  logic [15:0] addr;
  logic [7:0] wdata;
  logic done;
  logic [7:0] rdata;
  modport seq (output req, output wr, output addr, output wdata, input done, input rdata);
  modport eng (input req, input wr, input addr, input wdata, output done, output rdata);
endinterface

// ==== verilog/fcr_cycle.sv ====
// fcr_cycle: one write or read cycle on the flash pins
// assumes flash data input already passed through two flip-flops
`timescale 1ns/100ps
module fcr_cycle
  import fcr_pkg::*;
(
  input wire clock,
  input wire rst,
  fcr_bus_if.eng bus,
  input wire [7:0] dq_sync,
  output logic [15:0] fl_addr,
  output logic [7:0] fl_dq_o,
  output logic fl_dq_oe,
  output logic fl_ce_n,
  output logic fl_oe_n,
  output logic fl_we_n
);
  typedef enum logic [1:0] {CY_IDLE, CY_STROBE, CY_DONE} fcr_cy_t;
  typedef struct packed {
    fcr_cy_t st;
    logic [7:0] cnt;
    logic [15:0] addr;
    logic [7:0] wd;
    logic [7:0] rd;
    logic oe;
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic done;
  } fcr_cy_state_t;
  fcr_cy_state_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    case (s_q.st)
      CY_IDLE: begin
        if (bus.req) begin
          s_d.addr = bus.addr;
          s_d.wd = bus.wdata;
          s_d.oe = bus.wr;
          s_d.ce_n = 1'b0;
          s_d.we_n = ~bus.wr;
          s_d.oe_n = bus.wr;
          s_d.cnt = bus.wr ? 8'(WE_PULSE_CYC) : 8'(READ_ACC_CYC);
          s_d.st = CY_STROBE;
        end
      end
      CY_STROBE: begin
        if (s_q.cnt > 8'h01) begin
          s_d.cnt = s_q.cnt - 8'h01;
        end else begin
          // we rising edge latches data; data held one more cycle
          s_d.rd = dq_sync;
          s_d.we_n = 1'b1;
          s_d.oe_n = 1'b1;
          s_d.st = CY_DONE;
        end
      end
      CY_DONE: begin
        s_d.ce_n = 1'b1;
        s_d.oe = 1'b0;
        s_d.done = 1'b1;
        s_d.st = CY_IDLE;
      end
      default: s_d.st = CY_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_q <= '{st: CY_IDLE, cnt: 8'h00, addr: 16'h0000, wd: 8'h00, rd: 8'h00,
               oe: 1'b0, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, done: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign bus.done = s_q.done;
  assign bus.rdata = s_q.rd;
  assign fl_addr = s_q.addr;
  assign fl_dq_o = s_q.wd;
  assign fl_dq_oe = s_q.oe;
  assign fl_ce_n = s_q.ce_n;
  assign fl_oe_n = s_q.oe_n;
  assign fl_we_n = s_q.we_n;
endmodule

// ==== verilog/fcr_host.sv ====
// fcr_host: host controller issuing command sequences to a byte-wide flash
// assumes the user holds op stable while cmd_valid and a switchable vpp supply
`timescale 1ns/100ps
module fcr_host
  import fcr_pkg::*;
#(
  parameter int unsigned ERASE_CYC = ERASE_PULSE_CYC
)(
  input wire clock,
  input wire rst,
  input wire cmd_valid,
  input wire [2:0] cmd_op,
  input wire [15:0] cmd_addr,
  input wire [7:0] cmd_data,
  input wire abort_req,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic rsp_fail,
  output logic vpp_en,
  output logic [15:0] fl_addr,
  output logic [7:0] fl_dq_o,
  output logic fl_dq_oe,
  input wire [7:0] fl_dq_i,
  output logic fl_ce_n,
  output logic fl_oe_n,
  output logic fl_we_n
);
  typedef enum logic [3:0] {
    H_IDLE, H_VPP, H_W1, H_W2, H_DATA, H_PULSE, H_W3, H_RECOV, H_READ, H_FINISH
  } fcr_h_t;
  typedef struct packed {
    fcr_h_t st;
    fcr_op_t op;
    logic [CNT_W-1:0] cnt;
    logic [15:0] addr;
    logic [7:0] data;
    logic vpp;
    logic ready;
    logic rvalid;
    logic [7:0] rdata;
    logic fail;
    logic req;
    logic wr;
    logic [15:0] baddr;
    logic [7:0] bdata;
    logic [7:0] sync1;
    logic [7:0] sync2;
  } fcr_h_state_t;
  fcr_h_state_t s_q, s_d;
  fcr_bus_if bus();

  function automatic logic is_hv(input fcr_op_t op);
    is_hv = (op == FCR_OP_PROGRAM) || (op == FCR_OP_ERASE);
  endfunction

  always_comb begin
    s_d = s_q;
    s_d.rvalid = 1'b0;
    s_d.req = 1'b0;
    s_d.sync1 = fl_dq_i;
    s_d.sync2 = s_q.sync1;
    case (s_q.st)
      H_IDLE: begin
        if (cmd_valid && s_q.ready) begin
          s_d.ready = 1'b0;
          s_d.op = fcr_op_t'(cmd_op);
          s_d.addr = cmd_addr;
          s_d.data = cmd_data;
          s_d.fail = 1'b0;
          if (is_hv(fcr_op_t'(cmd_op))) begin
            s_d.vpp = 1'b1;
            s_d.cnt = CNT_W'(VPP_SETTLE_CYC);
            s_d.st = H_VPP;
          end else begin
            s_d.st = H_W1;
          end
        end
      end
      H_VPP: begin
        if (s_q.cnt > '0) s_d.cnt = s_q.cnt - 1'b1;
        else s_d.st = H_W1;
      end
      H_W1: begin
        s_d.req = 1'b1;
        s_d.wr = 1'b1;
        s_d.baddr = s_q.addr;
        s_d.st = H_W2;
        case (s_q.op)
          FCR_OP_PROGRAM: s_d.bdata = CMD_PROG_SETUP;
          FCR_OP_ERASE: s_d.bdata = CMD_ERASE_SETUP;
          FCR_OP_ERASE_VERIFY: s_d.bdata = CMD_ERASE_VERIFY;
          FCR_OP_IDENT: s_d.bdata = CMD_IDENT;
          FCR_OP_DESELECT: s_d.bdata = CMD_READ;
          FCR_OP_RESET: s_d.bdata = CMD_RESET;
          default: s_d.bdata = CMD_READ;
        endcase
      end
      default: ;
    endcase
    // sequencing driven from cycle completion
    if (bus.done) begin
      case (s_q.st)
        H_W2: begin
          case (s_q.op)
            FCR_OP_PROGRAM, FCR_OP_ERASE: begin
              s_d.req = 1'b1;
              s_d.bdata = (s_q.op == FCR_OP_PROGRAM) ? s_q.data : CMD_ERASE;
              s_d.st = H_DATA;
            end
            FCR_OP_RESET: begin
              s_d.req = 1'b1;
              s_d.st = H_FINISH;
            end
            FCR_OP_ERASE_VERIFY: begin
              s_d.cnt = CNT_W'(RECOVERY_CYC);
              s_d.st = H_RECOV;
            end
            FCR_OP_READ, FCR_OP_IDENT: begin
              s_d.req = 1'b1;
              s_d.wr = 1'b0;
              s_d.st = H_READ;
            end
            default: begin
              // deselect is a lone write with nothing to read back
              s_d.rvalid = 1'b1;
              s_d.ready = 1'b1;
              s_d.st = H_IDLE;
            end
          endcase
        end
        H_DATA: begin
          // pulse timed from the rising strobe of the data write, not from its request
          s_d.st = H_PULSE;
          s_d.cnt = (s_q.op == FCR_OP_PROGRAM) ? CNT_W'(PROG_PULSE_CYC)
                                               : CNT_W'(ERASE_CYC);
        end
        H_READ: begin
          s_d.rdata = bus.rdata;
          s_d.st = H_FINISH;
          s_d.rvalid = 1'b1;
          s_d.ready = 1'b1;
          s_d.st = H_IDLE;
        end
        H_W3: begin
          s_d.cnt = CNT_W'(RECOVERY_CYC);
          s_d.st = H_RECOV;
        end
        H_FINISH: begin
          s_d.rvalid = 1'b1;
          s_d.ready = 1'b1;
          s_d.st = H_IDLE;
        end
        default: ;
      endcase
    end
    if (s_q.st == H_PULSE && !bus.done && !s_q.req) begin
      if (s_q.cnt > '0 && !abort_req) begin
        s_d.cnt = s_q.cnt - 1'b1;
      end else begin
        // pulse always closed by verify write, also on early abort
        s_d.req = 1'b1;
        s_d.bdata = (s_q.op == FCR_OP_PROGRAM) ? CMD_PROG_VERIFY : CMD_ERASE_VERIFY;
        s_d.fail = abort_req;
        s_d.st = H_W3;
      end
    end
    if (s_q.st == H_RECOV) begin
      if (s_q.cnt > '0) begin
        s_d.cnt = s_q.cnt - 1'b1;
      end else begin
        s_d.req = 1'b1;
        s_d.wr = 1'b0;
        s_d.vpp = 1'b0;
        s_d.st = H_READ;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_q <= '{st: H_IDLE, op: FCR_OP_READ, cnt: '0, addr: 16'h0000, data: 8'h00,
               vpp: 1'b0, ready: 1'b1, rvalid: 1'b0, rdata: 8'h00, fail: 1'b0,
               req: 1'b0, wr: 1'b0, baddr: 16'h0000, bdata: 8'h00,
               sync1: 8'h00, sync2: 8'h00};
    end else begin
      s_q <= s_d;
    end
  end

  assign bus.req = s_q.req;
  assign bus.wr = s_q.wr;
  assign bus.addr = s_q.baddr;
  assign bus.wdata = s_q.bdata;
  assign cmd_ready = s_q.ready;
  assign rsp_valid = s_q.rvalid;
  assign rsp_data = s_q.rdata;
  assign rsp_fail = s_q.fail;
  assign vpp_en = s_q.vpp;

  fcr_cycle u_cycle (
    .clock(clock),
    .rst(rst),
    .bus(bus),
    .dq_sync(s_q.sync2),
    .fl_addr(fl_addr),
    .fl_dq_o(fl_dq_o),
    .fl_dq_oe(fl_dq_oe),
    .fl_ce_n(fl_ce_n),
    .fl_oe_n(fl_oe_n),
    .fl_we_n(fl_we_n)
  );

  a_pulse_verify: assert property (@(posedge clock) disable iff (rst)
    (s_q.st == H_PULSE && s_d.st == H_W3) |=> s_q.req && s_q.wr &&
    (s_q.bdata == CMD_PROG_VERIFY || s_q.bdata == CMD_ERASE_VERIFY))
    else $error("pulse not closed by verify write");
  a_recov_read: assert property (@(posedge clock) disable iff (rst)
    (s_q.st == H_W3 && bus.done) |=> (s_q.st == H_RECOV)[*8])
    else $error("read issued inside recovery");
  a_vpp_first: assert property (@(posedge clock) disable iff (rst)
    $rose(vpp_en) |-> !s_q.req [*8])
    else $error("command before vpp settled");
  a_hv_vpp: assert property (@(posedge clock) disable iff (rst)
    (s_q.st == H_PULSE) |-> vpp_en)
    else $error("pulse without vpp");
  a_reset_twice: assert property (@(posedge clock) disable iff (rst)
    (s_q.st == H_W2 && s_q.op == FCR_OP_RESET && bus.done) |=>
    s_q.req && s_q.bdata == CMD_RESET)
    else $error("reset not repeated");
  a_prog_len: assert property (@(posedge clock) disable iff (rst)
    (s_q.st == H_PULSE && s_q.op == FCR_OP_PROGRAM && $past(s_q.st) == H_DATA)
    |-> s_q.cnt == CNT_W'(PROG_PULSE_CYC))
    else $error("program pulse length wrong");
  a_abort_end: assert property (@(posedge clock) disable iff (rst)
    (s_q.st == H_PULSE && abort_req && !bus.done && !s_q.req) |=> s_q.st == H_W3)
    else $error("abort did not end pulse");
  a_ready_busy: assert property (@(posedge clock) disable iff (rst)
    (cmd_valid && cmd_ready) |=> !cmd_ready)
    else $error("ready stayed high after accept");
endmodule

// ==== verilog/fcr_pkg.sv ====
// fcr_pkg: constants and types for the flash command host controller
// assumes a 125 MHz system clock and a byte-wide flash bus outside
package fcr_pkg;
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned VPP_SETTLE_NS = 100;
  localparam int unsigned ERASE_PULSE_MS = 10;
  localparam int unsigned PROG_PULSE_US = 10;
  localparam int unsigned RECOVERY_US = 6;
  localparam int unsigned WE_PULSE_NS = 80;
  localparam int unsigned READ_ACC_NS = 240;
  localparam int unsigned VPP_SETTLE_CYC = (VPP_SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned ERASE_PULSE_CYC = ERASE_PULSE_MS * 1000 * CLK_MHZ;
  localparam int unsigned PROG_PULSE_CYC = PROG_PULSE_US * CLK_MHZ;
  localparam int unsigned RECOVERY_CYC = RECOVERY_US * CLK_MHZ;
  localparam int unsigned WE_PULSE_CYC = (WE_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned READ_ACC_CYC = (READ_ACC_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 24;

  localparam logic [7:0] CMD_READ = 8'h00;
  localparam logic [7:0] CMD_IDENT = 8'h90;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
  localparam logic [7:0] CMD_ERASE = 8'h20;
  localparam logic [7:0] CMD_ERASE_VERIFY = 8'ha0;
  localparam logic [7:0] CMD_PROG_SETUP = 8'h40;
  localparam logic [7:0] CMD_PROG_VERIFY = 8'hc0;
  localparam logic [7:0] CMD_RESET = 8'hff;
  localparam logic [15:0] ADDR_MAKER = 16'h0000;
  localparam logic [15:0] ADDR_PART = 16'h0001;

  typedef enum logic [2:0] {
    FCR_OP_READ, FCR_OP_PROGRAM, FCR_OP_ERASE, FCR_OP_ERASE_VERIFY,
    FCR_OP_IDENT, FCR_OP_RESET, FCR_OP_DESELECT
  } fcr_op_t;
endpackage
